// ### wrxc_ctrl.sv
// Contract
// - Error packet every 30 ms above target
// - Then error packet every 250 ms
// - Overvoltage disables regulator, requests lower voltage
// - Open mode pins select adapter-control mode
// - No adapter: gate held high, switch off
// - Adapter present: wireless off, gate low (code keeps wireless on in mode 01 and gate high in mode 11)
// - Mode 00: adapter first, comm limit on
// - Mode 01: comm limit disabled
// - Select A low: select B sets priority
// - Select A high: wireless off, B gates wired
// - Mode 10: gate low, boost-back, reason 00
// - Boost-back lets output supply adapter terminal
// - Mode 11: nothing delivered, reason 01
// - End-transfer packet: header 02, one reason byte
// - Fault conditions map to reasons 00/02/03
// - No convergence gives 04; others never sent
// - Status flag on while output enabled
// - Output off until regulation converged
// - Shutdown at start-up ends transfer immediately
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "wrxc_defs.svh"

module wrxc_ctrl
  import wrxc_pkg::*;
#(
  parameter int FAST_CYCLES     = `WRXC_FAST_MS * `WRXC_CLK_MHZ * 1000,
  parameter int SLOW_CYCLES     = `WRXC_SLOW_MS * `WRXC_CLK_MHZ * 1000,
  parameter int DEBOUNCE_CYCLES = `WRXC_DEBOUNCE_US * `WRXC_CLK_MHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  input  wire logic        adapter_present,
  input  wire logic        rect_above_target,
  input  wire logic        rect_overvoltage,
  input  wire logic        rect_converged,
  input  wire logic [7:0]  fault_in,
  output logic             adapter_gate_low,
  output logic             wireless_enable,
  output logic             wired_enable,
  output logic             boost_back_enable,
  output logic             comm_limit_enable,
  output logic             regulator_enable,
  output logic             output_active_flag_o,
  output logic             output_active_flag_oe,
  output logic             pkt_valid,
  output logic      [7:0]  pkt_header,
  output logic      [7:0]  pkt_data,
  input  wire logic        pkt_ready
);

  logic [1:0]    sync_a;
  logic [1:0]    sync_b;
  logic [9:0]    sync_f;
  logic [9:0]    sync_f2;
  logic [1:0]    raw_mode;
  logic [1:0]    cand_mode;
  logic [31:0]   deb_cnt;
  wrxc_mode_type mode;
  logic          mode_valid;
  wrxc_ov_type   ov_state;
  logic [31:0]   ov_cnt;
  logic          err_req;
  logic          ept_sent;
  logic          ctrl_send_ept;
  logic          startup;
  logic          ept_req;
  logic [7:0]    ept_reason;
  logic          ept_cond;
  logic [7:0]    flt;
  logic          adp;
  logic          above;
  logic          ovp;
  logic          conv;
  logic          apb_wr;
  logic          apb_rd;

  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign pslverr = psel && penable &&
                   !(paddr == `WRXC_ADDR_CTRL || paddr == `WRXC_ADDR_STATUS ||
                     paddr == `WRXC_ADDR_PKT  || paddr == `WRXC_ADDR_FAULT);

  // Two-flop synchronisers for all pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a  <= 2'b00;
      sync_b  <= 2'b00;
      sync_f  <= 10'h000;
      sync_f2 <= 10'h000;
    end else begin
      sync_a  <= {sync_a[0], mode_select_a};
      sync_b  <= {sync_b[0], mode_select_b};
      sync_f  <= {fault_in, adapter_present, rect_converged};
      sync_f2 <= sync_f;
    end
  end

  assign raw_mode = {sync_a[1], sync_b[1]};
  assign flt      = sync_f2[9:2];
  assign adp      = sync_f2[1];
  assign conv     = sync_f2[0];

  logic [1:0] sync_v0;
  logic [1:0] sync_v1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_v0 <= 2'b00;
      sync_v1 <= 2'b00;
    end else begin
      sync_v0 <= {rect_above_target, rect_overvoltage};
      sync_v1 <= sync_v0;
    end
  end
  assign above = sync_v1[1];
  assign ovp   = sync_v1[0];

  // Debounce: mode changes only after stable level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_mode  <= 2'b00;
      deb_cnt    <= 32'h0000_0000;
      mode       <= WRXC_MODE_ADAPTER;
      mode_valid <= 1'b0;
    end else if (raw_mode != cand_mode) begin
      cand_mode <= raw_mode;
      deb_cnt   <= 32'h0000_0000;
    end else if (deb_cnt >= 32'(DEBOUNCE_CYCLES - 1)) begin
      mode       <= wrxc_mode_type'(cand_mode);
      mode_valid <= 1'b1;
    end else begin
      deb_cnt <= deb_cnt + 32'h0000_0001;
    end
  end

  // Power path decode from mode
  always_comb begin
    adapter_gate_low  = 1'b0;
    wireless_enable   = 1'b0;
    wired_enable      = 1'b0;
    boost_back_enable = 1'b0;
    comm_limit_enable = 1'b0;
    case (mode)
      WRXC_MODE_ADAPTER: begin
        comm_limit_enable = 1'b1;
        adapter_gate_low  = adp;
        wired_enable      = adp;
        wireless_enable   = !adp;
      end
      WRXC_MODE_NOLIMIT: begin
        comm_limit_enable = 1'b0;
        adapter_gate_low  = adp;
        wired_enable      = adp;
        wireless_enable   = 1'b1;
      end
      WRXC_MODE_BOOST: begin
        adapter_gate_low  = 1'b1;
        wired_enable      = adp;
        boost_back_enable = 1'b1;
      end
      WRXC_MODE_DISABLED: begin
        adapter_gate_low  = 1'b0;
      end
      default: begin
        adapter_gate_low  = 1'b0;
      end
    endcase
  end

  // Regulator and status flag
  always_comb begin
    regulator_enable = conv && !ovp && (mode != WRXC_MODE_DISABLED)
                       && !ept_sent;
    output_active_flag_o  = 1'b0;
    output_active_flag_oe = regulator_enable;
  end

  // End-transfer reason by fixed priority, faults first
  always_comb begin
    ept_cond   = 1'b1;
    ept_reason = `WRXC_EPT_UNKNOWN;
    if (flt[`WRXC_F_TJ_HOT] || flt[`WRXC_F_ILIM_SMALL]) begin
      ept_reason = `WRXC_EPT_INTERNAL;
    end else if (flt[`WRXC_F_HOT] || flt[`WRXC_F_CTRL_LOW]) begin
      ept_reason = `WRXC_EPT_OVERTEMP;
    end else if (flt[`WRXC_F_NO_CONVERGE]) begin
      ept_reason = `WRXC_EPT_OVERVOLT;
    end else if (flt[`WRXC_F_ADAPTER] || flt[`WRXC_F_CTRL_HIGH] ||
                 flt[`WRXC_F_COLD]) begin
      ept_reason = `WRXC_EPT_UNKNOWN;
    end else if (mode_valid && mode == WRXC_MODE_BOOST) begin
      ept_reason = `WRXC_EPT_UNKNOWN;
    end else if (mode_valid && mode == WRXC_MODE_DISABLED) begin
      ept_reason = `WRXC_EPT_COMPLETE;
    end else begin
      ept_cond   = 1'b0;
    end
  end

  // Overvoltage error packet pacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_state <= WRXC_OV_IDLE;
      ov_cnt   <= 32'h0000_0000;
      err_req  <= 1'b0;
    end else begin
      if (pkt_valid && pkt_ready && pkt_header == `WRXC_HDR_ERROR) begin
        err_req <= 1'b0;
      end
      case (ov_state)
        WRXC_OV_IDLE: begin
          if (above || ovp) begin
            ov_state <= WRXC_OV_FAST;
            ov_cnt   <= 32'h0000_0000;
            err_req  <= 1'b1;
          end
        end
        WRXC_OV_FAST: begin
          if (!above && !ovp) begin
            ov_state <= WRXC_OV_SLOW;
            ov_cnt   <= 32'h0000_0000;
          end else if (ov_cnt >= 32'(FAST_CYCLES - 1)) begin
            ov_cnt  <= 32'h0000_0000;
            err_req <= 1'b1;
          end else begin
            ov_cnt <= ov_cnt + 32'h0000_0001;
          end
        end
        WRXC_OV_SLOW: begin
          if (above || ovp) begin
            ov_state <= WRXC_OV_FAST;
            ov_cnt   <= 32'h0000_0000;
            err_req  <= 1'b1;
          end else if (ov_cnt >= 32'(SLOW_CYCLES - 1)) begin
            ov_cnt  <= 32'h0000_0000;
            err_req <= 1'b1;
          end else begin
            ov_cnt <= ov_cnt + 32'h0000_0001;
          end
        end
        default: begin
          ov_state <= WRXC_OV_IDLE;
        end
      endcase
    end
  end

  // End-transfer request: one packet per condition episode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ept_req  <= 1'b0;
      ept_sent <= 1'b0;
    end else begin
      if (pkt_valid && pkt_ready && pkt_header == `WRXC_HDR_EPT) begin
        ept_req  <= 1'b0;
        ept_sent <= 1'b1;
      end else if (((ept_cond && (mode_valid || startup)) || ctrl_send_ept)
                   && !ept_sent && !ept_req) begin
        ept_req <= 1'b1;
      end
      if (!ept_cond && !ctrl_send_ept && !ept_req) begin
        ept_sent <= 1'b0;
      end
    end
  end

  // Packet output: end-transfer ahead of error packets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_valid  <= 1'b0;
      pkt_header <= 8'h00;
      pkt_data   <= 8'h00;
    end else if (!pkt_valid || pkt_ready) begin
      if (ept_req && !(pkt_valid && pkt_header == `WRXC_HDR_EPT)) begin
        pkt_valid  <= 1'b1;
        pkt_header <= `WRXC_HDR_EPT;
        pkt_data   <= ept_reason;
      end else if (err_req && !(pkt_valid && pkt_header == `WRXC_HDR_ERROR)) begin
        pkt_valid  <= 1'b1;
        pkt_header <= `WRXC_HDR_ERROR;
        pkt_data   <= {7'h00, ovp};
      end else begin
        pkt_valid <= 1'b0;
      end
    end
  end

  // Software control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_send_ept <= 1'b0;
      startup       <= 1'b1;
    end else if (apb_wr && paddr == `WRXC_ADDR_CTRL) begin
      ctrl_send_ept <= pwdata[`WRXC_CTRL_SEND_EPT];
      startup       <= pwdata[`WRXC_CTRL_STARTUP];
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      case (paddr)
        `WRXC_ADDR_CTRL:   prdata <= {30'h0, startup, ctrl_send_ept};
        `WRXC_ADDR_STATUS: prdata <= {20'h0, ov_state, ept_sent, ept_req,
                                      regulator_enable, boost_back_enable,
                                      wireless_enable, wired_enable, mode_valid,
                                      comm_limit_enable, mode};
        `WRXC_ADDR_PKT:    prdata <= {15'h0, pkt_valid, pkt_header, pkt_data};
        `WRXC_ADDR_FAULT:  prdata <= {16'h0, ept_reason, flt};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : wrxc_ctrl

// ### wrxc_defs.svh
`ifndef WRXC_DEFS_SVH
`define WRXC_DEFS_SVH

// APB register byte offsets
`define WRXC_ADDR_CTRL      8'h00
`define WRXC_ADDR_STATUS    8'h04
`define WRXC_ADDR_PKT       8'h08
`define WRXC_ADDR_FAULT     8'h0C

// Control register fields
`define WRXC_CTRL_SEND_EPT  0
`define WRXC_CTRL_STARTUP   1

// Fault input bit positions
`define WRXC_F_ADAPTER      0
`define WRXC_F_CTRL_HIGH    1
`define WRXC_F_COLD         2
`define WRXC_F_TJ_HOT       3
`define WRXC_F_ILIM_SMALL   4
`define WRXC_F_HOT          5
`define WRXC_F_CTRL_LOW     6
`define WRXC_F_NO_CONVERGE  7

// Packet headers and reason codes
`define WRXC_HDR_ERROR      8'h03
`define WRXC_HDR_EPT        8'h02
`define WRXC_EPT_UNKNOWN    8'h00
`define WRXC_EPT_COMPLETE   8'h01
`define WRXC_EPT_INTERNAL   8'h02
`define WRXC_EPT_OVERTEMP   8'h03
`define WRXC_EPT_OVERVOLT   8'h04

// Timing
`define WRXC_CLK_MHZ        200
`define WRXC_FAST_MS        30
`define WRXC_SLOW_MS        250
`define WRXC_DEBOUNCE_US    1000

`endif

// ### wrxc_pkg.sv
package wrxc_pkg;
  typedef enum logic [1:0] {
    WRXC_MODE_ADAPTER  = 2'b00,
    WRXC_MODE_NOLIMIT  = 2'b01,
    WRXC_MODE_BOOST    = 2'b10,
    WRXC_MODE_DISABLED = 2'b11
  } wrxc_mode_type;

  typedef enum logic [1:0] {
    WRXC_OV_IDLE = 2'b00,
    WRXC_OV_FAST = 2'b01,
    WRXC_OV_SLOW = 2'b10
  } wrxc_ov_type;
endpackage : wrxc_pkg

// ### wrxc_ctrl_monitor.sv
`timescale 1ns/1ps
module wrxc_ctrl_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       rect_overvoltage,
  input wire logic       adapter_gate_low,
  input wire logic       wireless_enable,
  input wire logic       boost_back_enable,
  input wire logic       comm_limit_enable,
  input wire logic       regulator_enable,
  input wire logic       output_active_flag_o,
  input wire logic       output_active_flag_oe,
  input wire logic       pkt_valid,
  input wire logic [7:0] pkt_header,
  input wire logic [7:0] pkt_data,
  input wire logic       pkt_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_flag_follows_reg: assert property ($stable(regulator_enable) |->
    output_active_flag_oe == regulator_enable) else $error("flag differs from regulator");
  a_flag_drive_low: assert property (output_active_flag_o == 1'b0)
    else $error("flag pin driven high");
  a_pkt_held: assert property (pkt_valid && !pkt_ready |=> pkt_valid &&
    $stable(pkt_header) && $stable(pkt_data)) else $error("packet dropped or changed");
  a_ept_reason_legal: assert property (pkt_valid && pkt_header == 8'h02
    |-> pkt_data <= 8'h04) else $error("reason code never sent");
  a_boost_gate_low: assert property (boost_back_enable |->
    adapter_gate_low && !wireless_enable) else $error("boost-back without gate low");
  a_ovp_reg_off: assert property (rect_overvoltage [*4] |-> !regulator_enable)
    else $error("regulator on in overvoltage");
  a_comm_mode_zero: assert property (comm_limit_enable |->
    wireless_enable != adapter_gate_low) else $error("adapter mode source choice wrong");
  a_slverr_unmapped: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access not refused");
  c_error_pkt: cover property (pkt_valid && pkt_ready && pkt_header == 8'h03);
  c_ept_pkt: cover property (pkt_valid && pkt_ready && pkt_header == 8'h02);
  c_boost: cover property (boost_back_enable);
  c_ovp: cover property (rect_overvoltage [*4]);
endmodule : wrxc_ctrl_monitor

bind wrxc_ctrl wrxc_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .rect_overvoltage(rect_overvoltage),
  .adapter_gate_low(adapter_gate_low), .wireless_enable(wireless_enable),
  .boost_back_enable(boost_back_enable), .comm_limit_enable(comm_limit_enable),
  .regulator_enable(regulator_enable), .output_active_flag_o(output_active_flag_o),
  .output_active_flag_oe(output_active_flag_oe), .pkt_valid(pkt_valid),
  .pkt_header(pkt_header), .pkt_data(pkt_data), .pkt_ready(pkt_ready));

// ### wrxc_tx_model.sv
`timescale 1ns/1ps
module wrxc_tx_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       stall,
  input  wire logic       pkt_valid,
  input  wire logic [7:0] pkt_header,
  input  wire logic [7:0] pkt_data,
  output logic            pkt_ready,
  output int              count,
  output int              gap,
  output logic [7:0]      last_hdr,
  output logic [7:0]      last_data
);
  int wait_n;
  int since;
  // When stalled, slow decoder takes a packet only after three wait cycles
  assign pkt_ready = pkt_valid && (!stall || wait_n == 3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_n <= 0;
      since <= 0;
      count <= 0;
      gap <= 0;
      last_hdr <= 8'h00;
      last_data <= 8'h00;
    end else begin
      since <= since + 1;
      wait_n <= (pkt_valid && !pkt_ready) ? wait_n + 1 : 0;
      if (pkt_valid && pkt_ready) begin
        count <= count + 1;
        gap <= since;
        since <= 1;
        last_hdr <= pkt_header;
        last_data <= pkt_data;
      end
    end
  end
endmodule : wrxc_tx_model

// ### wrxc_ctrl_test.sv
`timescale 1ns/1ps
module wrxc_ctrl_test;
  import wrxc_pkg::*;
  localparam int FAST = 20;
  localparam int SLOW = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
  logic [7:0] paddr, fault_in, pkt_header, pkt_data, last_hdr, last_data;
  logic [31:0] pwdata, prdata;
  logic mode_select_a, mode_select_b, adapter_present, rect_above_target;
  logic rect_overvoltage, rect_converged, adapter_gate_low, wireless_enable;
  logic wired_enable, boost_back_enable, comm_limit_enable, regulator_enable;
  logic output_active_flag_o, output_active_flag_oe, pkt_valid, pkt_ready;
  int count, gap, mismatches, checks_done;

  wrxc_ctrl #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW), .DEBOUNCE_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select_a(mode_select_a), .mode_select_b(mode_select_b),
    .adapter_present(adapter_present), .rect_above_target(rect_above_target),
    .rect_overvoltage(rect_overvoltage), .rect_converged(rect_converged),
    .fault_in(fault_in), .adapter_gate_low(adapter_gate_low),
    .wireless_enable(wireless_enable), .wired_enable(wired_enable),
    .boost_back_enable(boost_back_enable), .comm_limit_enable(comm_limit_enable),
    .regulator_enable(regulator_enable), .output_active_flag_o(output_active_flag_o),
    .output_active_flag_oe(output_active_flag_oe), .pkt_valid(pkt_valid),
    .pkt_header(pkt_header), .pkt_data(pkt_data), .pkt_ready(pkt_ready));

  wrxc_tx_model u_tx (.pclk(pclk), .presetn(presetn), .stall(stall), .pkt_valid(pkt_valid),
    .pkt_header(pkt_header), .pkt_data(pkt_data), .pkt_ready(pkt_ready), .count(count),
    .gap(gap), .last_hdr(last_hdr), .last_data(last_data));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Host drives both pins actively, then waits out sync and debounce
  task pins(input logic a, input logic b);
    @(posedge pclk);
    mode_select_a <= a;
    mode_select_b <= b;
    repeat (15) @(posedge pclk);
    #1;
  endtask : pins

  task expect_pkt(input int c, input logic [7:0] h, input logic [7:0] d);
    int n;
    n = 0;
    while (count == c && n < 200) begin @(posedge pclk); n++; end
    #1;
    chk("packet arrived", 32'h1, {31'h0, count != c});
    chk("packet header", {24'h0, h}, {24'h0, last_hdr});
    chk("packet data", {24'h0, d}, {24'h0, last_data});
    // Back on a rising edge so callers drive on it
    @(posedge pclk);
  endtask : expect_pkt

  task t_reset;
    logic [31:0] r;
    logic        e;
    pins(1'b0, 1'b0);
    apb(1'b0, 8'h00, r, e);
    chk("ctrl reset", 32'h2, {30'h0, r[1:0]});
    apb(1'b1, 8'h00, r, e);
    apb(1'b0, 8'h00, r, e);
    chk("ctrl write", 32'h0, {30'h0, r[1:0]});
    apb(1'b0, 8'h10, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h04, r, e);
    chk("mode field", 32'h0, {30'h0, r[1:0]});
    chk("comm limit", 32'h1, {31'h0, comm_limit_enable});
    chk("gate idle", 32'h0, {31'h0, adapter_gate_low});
    @(posedge pclk);
    adapter_present <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    chk("gate adapter", 32'h1, {31'h0, adapter_gate_low});
    chk("wireless off", 32'h0, {31'h0, wireless_enable});
    chk("no packet", 32'h0, count);
  endtask : t_reset

  task t_modes;
    int c;
    c = count;
    pins(1'b0, 1'b1);
    chk("comm off", 32'h0, {31'h0, comm_limit_enable});
    chk("both usable", 32'h3, {30'h0, wired_enable, wireless_enable});
    chk("no ept", c, count);
    pins(1'b1, 1'b0);
    chk("boost outs", 32'h7, {29'h0, adapter_gate_low, boost_back_enable, wired_enable});
    chk("wl off", 32'h0, {31'h0, wireless_enable});
    expect_pkt(c, 8'h02, 8'h00);
    pins(1'b0, 1'b0);
    c = count;
    pins(1'b1, 1'b1);
    chk("all off", 32'h0, {29'h0, wired_enable, wireless_enable, regulator_enable});
    expect_pkt(c, 8'h02, 8'h01);
    pins(1'b0, 1'b0);
    @(posedge pclk);
    adapter_present <= 1'b0;
  endtask : t_modes

  task t_faults;
    logic [7:0] fb [9];
    logic [7:0] rs [9];
    int         c;
    fb = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hA8};
    rs = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h03, 8'h03, 8'h04, 8'h02};
    for (int i = 0; i < 9; i++) begin
      c = count;
      @(posedge pclk);
      fault_in <= fb[i];
      expect_pkt(c, 8'h02, rs[i]);
      fault_in <= 8'h00;
      repeat (10) @(posedge pclk);
    end
  endtask : t_faults

  task t_ovp;
    int c;
    c = count;
    stall <= 1'b1;
    rect_above_target <= 1'b1;
    expect_pkt(c, 8'h03, 8'h00);
    stall <= 1'b0;
    expect_pkt(count, 8'h03, 8'h00);
    expect_pkt(count, 8'h03, 8'h00);
    chk("fast gap", 32'h1, {31'h0, gap >= FAST - 1 && gap <= FAST + 1});
    rect_above_target <= 1'b0;
    expect_pkt(count, 8'h03, 8'h00);
    expect_pkt(count, 8'h03, 8'h00);
    chk("slow gap", 32'h1, {31'h0, gap >= SLOW - 1 && gap <= SLOW + 1});
    c = count;
    rect_overvoltage <= 1'b1;
    expect_pkt(c, 8'h03, 8'h01);
    chk("ldo off", 32'h0, {31'h0, regulator_enable});
    rect_overvoltage <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk("reg back on", 32'h3, {30'h0, regulator_enable, output_active_flag_oe});
    @(posedge pclk);
    rect_converged <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk("reg unconverged", 32'h0, {30'h0, regulator_enable, output_active_flag_oe});
  endtask : t_ovp

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; mode_select_a = 1'b0; mode_select_b = 1'b0; adapter_present = 1'b0;
    rect_above_target = 1'b0; rect_overvoltage = 1'b0; rect_converged = 1'b1;
    fault_in = 8'h00; stall = 1'b0; mismatches = 0; checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_faults();
    t_ovp();
    summarize();
  end

  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule : wrxc_ctrl_test
